// >>> common/rsc_cfg.svh
// constants of the reset-source controller
`ifndef RSC_CFG_SVH
`define RSC_CFG_SVH

// clock and times
`define RSC_CLK_HZ          25000000
`define RSC_SRESET_NS       45000
`define RSC_DEBOUNCE_NS     120000
`define RSC_CNT_W           16

// register byte offsets
`define RSC_ADR_SDC         8'h00
`define RSC_ADR_FLAGS       8'h04
`define RSC_ADR_IRQ_STS     8'h08
`define RSC_ADR_IRQ_MSK     8'h0C
`define RSC_ADR_WDTC        8'h10
`define RSC_ADR_STATUS      8'h14

// supply threshold select codes
`define RSC_SDC_POR         8'h5A
`define RSC_SDC_OFF         8'hA5

// watchdog control, key in bits 7:3, period in bits 2:0
`define RSC_WDTC_POR        8'h53
`define RSC_WKEY_ON         5'h0A
`define RSC_WKEY_OFF        5'h15
`define RSC_WKEY_HI         7
`define RSC_WKEY_LO         3
`define RSC_WSEL_HI         2
`define RSC_WSEL_POR        3'h3

// reset-source flag bits
`define RSC_BIT_WKF         0
`define RSC_BIT_TSF         1
`define RSC_BIT_SDF         2
`define RSC_FLAGS_W         3

// interrupt status bits: flag bits plus watchdog expiry
`define RSC_BIT_IRQ_WDT     3
`define RSC_IRQ_W           4

`endif

// >>> common/rsc_pkg.sv
// types of the reset-source controller
package rsc_pkg;

    typedef enum logic [2:0] {
        RSC_SEQ_IDLE  = 3'b001,
        RSC_SEQ_WAIT  = 3'b010,
        RSC_SEQ_PULSE = 3'b100
    } rsc_seq_t;

    // initialisation commands issued on power-on and full resets
    typedef struct packed {
        logic int_disable;
        logic wdt_tb_clear;
        logic timers_off;
        logic gpio_input;
        logic pc_zero;
        logic sp_top;
    } rsc_init_t;

    typedef struct packed {
        logic [15:0] cnt;
        logic        tripped;
        logic        trip;
    } rsc_deb_state_t;

    typedef struct packed {
        rsc_seq_t    seq;
        logic [15:0] cnt;
        logic        keep_sdc;
        logic [7:0]  sdc;
        logic [7:0]  wdtc;
        logic [2:0]  flags;
        logic        expiry;
        logic        pdown;
        logic        lp_d;
        logic [3:0]  irq_sts;
        logic [3:0]  irq_msk;
        logic        ack;
        logic [7:0]  dat;
        logic        irq;
        logic        sys_reset;
        logic        pc_sp_clear;
        rsc_init_t   init;
        logic        wdt_en;
        logic [2:0]  wdt_sel;
    } rsc_state_t;

endpackage

// >>> hw/rsc_debounce.sv
// persistence filter for the low-voltage indication
`timescale 1ns/1ps
`default_nettype none
`include "rsc_cfg.svh"

module rsc_debounce #(
    parameter logic [`RSC_CNT_W-1:0] CYCLES = 16'h0BB8
) (
    // clock and reset
    input  wire logic clk_sys_i,
    input  wire logic rst_i,
    // filter
    input  wire logic enable_i,
    input  wire logic level_i,
    output logic      trip_o
);

    rsc_pkg::rsc_deb_state_t r;
    rsc_pkg::rsc_deb_state_t next_r;

    always_comb
    begin
        next_r      = r;
        next_r.trip = 1'b0;
        if (!enable_i || !level_i)
        begin
            next_r.cnt     = '0;
            next_r.tripped = 1'b0;
        end
        else if (!r.tripped)
        begin
            // must persist longer than the debounce time
            if (r.cnt == CYCLES)
            begin
                next_r.trip    = 1'b1;
                next_r.tripped = 1'b1;
            end
            else
            begin
                next_r.cnt = r.cnt + 16'h0001;
            end
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            r <= '0;
        end
        else
        begin
            r <= next_r;
        end
    end

    assign trip_o = r.trip;

endmodule // rsc_debounce
`default_nettype wire

// >>> hw/rsc_top.sv
// reset-source controller with wishbone register access
//
// Chosen here: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "rsc_cfg.svh"

////////////////////////////////////////////////////////////////////////////////
// Functional notes
// - code 5A enables supply-drop reset at 1.7V, code A5 disables it
// - any other threshold code forces full reset restoring the code to 5A
// - that forced reset waits for the soft reset delay first
// - supply-drop reset needs low level beyond debounce time, keeps threshold code
// - supply-drop reset sets flag bit 2; only software clears it
// - undefined threshold code sets flag bit 1; only software clears it
// - flag register bits 7 to 3 read as zero
// - watchdog expiry while running gives full reset and sets expiry flag
// - watchdog expiry in sleep or idle clears only PC and SP, sets flag
// - power-on clears expiry and powerdown flags; supply-drop reset keeps them
// - expiry in low power leaves both flags at 1; running keeps powerdown
// - power-on reset disables all interrupt sources
// - power-on reset clears watchdog and time bases, watchdog then counts
// - power-on reset switches all timer modules off
// - power-on reset makes all general purpose pins inputs
// - power-on reset zeroes PC and points SP at stack top
// - bad watchdog enable key sets flag bit 0; only software clears it
// - supply-drop reset is off in idle or sleep, whatever the code
module rsc_top #(
    parameter int SRESET_NS   = `RSC_SRESET_NS,
    parameter int DEBOUNCE_NS = `RSC_DEBOUNCE_NS
) (
    // clock and reset
    input  wire logic        clk_sys_i,
    input  wire logic        rst_i,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // monitored conditions
    input  wire logic        low_voltage_i,
    input  wire logic        low_power_i,
    input  wire logic        wdt_expire_i,
    // reset actions
    output logic             sys_reset_o,
    output logic             pc_sp_clear_o,
    output rsc_pkg::rsc_init_t init_o,
    // watchdog control
    output logic             wdt_enable_o,
    output logic      [2:0]  wdt_period_o,
    // interrupt
    output logic             irq_o
);

    ////////////////////////////////////////////////////////////////////////////
    // timing

    localparam int MHZ        = `RSC_CLK_HZ / 1000000;
    localparam int SRESET_CYC = (SRESET_NS * MHZ + 999) / 1000;
    localparam int DEB_CYC    = (DEBOUNCE_NS * MHZ + 999) / 1000;
    localparam logic [`RSC_CNT_W-1:0] SRESET_LAST = `RSC_CNT_W'(SRESET_CYC - 1);
    localparam logic [`RSC_CNT_W-1:0] DEB_COUNT   = `RSC_CNT_W'(DEB_CYC);

    ////////////////////////////////////////////////////////////////////////////
    // decode helpers

    function automatic logic sdc_valid(input logic [7:0] v);
        sdc_valid = (v == `RSC_SDC_POR) || (v == `RSC_SDC_OFF);
    endfunction

    function automatic logic wkey_valid(input logic [7:0] v);
        logic [4:0] k;
        k          = v[`RSC_WKEY_HI:`RSC_WKEY_LO];
        wkey_valid = (k == `RSC_WKEY_ON) || (k == `RSC_WKEY_OFF);
    endfunction

    function automatic logic wkey_on(input logic [7:0] v);
        wkey_on = (v[`RSC_WKEY_HI:`RSC_WKEY_LO] == `RSC_WKEY_ON);
    endfunction

    function automatic logic adr_is(input logic [7:0] a, input logic [7:0] off);
        adr_is = (a[7:2] == off[7:2]);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // state

    rsc_pkg::rsc_state_t r;
    rsc_pkg::rsc_state_t next_r;

    logic                  sd_trip;
    logic                  sd_armed;
    logic                  bus_req;
    logic                  wr_lane0;
    logic [`RSC_IRQ_W-1:0] irq_ev;
    logic [`RSC_IRQ_W-1:0] irq_sts_kept;

    assign bus_req  = wb_cyc_i && wb_stb_i && !r.ack;
    assign wr_lane0 = bus_req && wb_we_i && wb_sel_i[0];

    // supply-drop monitor armed only with enable code and while running
    assign sd_armed = (r.sdc == `RSC_SDC_POR) && !low_power_i;

    rsc_debounce #(
        .CYCLES    (DEB_COUNT)
    ) u_debounce (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .enable_i  (sd_armed),
        .level_i   (low_voltage_i),
        .trip_o    (sd_trip)
    );

    ////////////////////////////////////////////////////////////////////////////
    // interrupt status: sticky, write one to clear, set wins

    // flag rising events from the set conditions, not from next_r, to avoid a loop
    assign irq_ev[`RSC_BIT_WKF]     = wr_lane0 && adr_is(wb_adr_i, `RSC_ADR_WDTC)
        && !wkey_valid(wb_dat_i[7:0]) && !r.flags[`RSC_BIT_WKF];
    assign irq_ev[`RSC_BIT_TSF]     = !sdc_valid(r.sdc) && !r.flags[`RSC_BIT_TSF];
    assign irq_ev[`RSC_BIT_SDF]     = sd_trip;
    assign irq_ev[`RSC_BIT_IRQ_WDT] = wdt_expire_i;

    genvar gi;
    generate
        for (gi = 0; gi < `RSC_IRQ_W; gi++)
        begin : g_irq
            assign irq_sts_kept[gi] = irq_ev[gi] || (r.irq_sts[gi] && !(wr_lane0
                && adr_is(wb_adr_i, `RSC_ADR_IRQ_STS) && wb_dat_i[gi]));
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb
    begin
        logic soft_fault;
        logic wdt_run_exp;
        soft_fault  = 1'b0;
        wdt_run_exp = 1'b0;
        next_r             = r;
        next_r.ack         = 1'b0;
        next_r.sys_reset   = 1'b0;
        next_r.pc_sp_clear = 1'b0;
        next_r.init        = '0;
        next_r.lp_d        = low_power_i;

        // register writes
        if (wr_lane0)
        begin
            if (adr_is(wb_adr_i, `RSC_ADR_SDC))
            begin
                next_r.sdc = wb_dat_i[7:0];
            end
            if (adr_is(wb_adr_i, `RSC_ADR_FLAGS))
            begin
                // writing zero clears, writing one leaves the flag alone
                next_r.flags = r.flags & wb_dat_i[`RSC_FLAGS_W-1:0];
            end
            if (adr_is(wb_adr_i, `RSC_ADR_IRQ_MSK))
            begin
                next_r.irq_msk = wb_dat_i[`RSC_IRQ_W-1:0];
            end
            if (adr_is(wb_adr_i, `RSC_ADR_WDTC))
            begin
                next_r.wdtc = wb_dat_i[7:0];
                if (!wkey_valid(wb_dat_i[7:0]))
                begin
                    next_r.flags[`RSC_BIT_WKF] = 1'b1;
                    soft_fault = 1'b1;
                end
            end
        end
        next_r.irq_sts = irq_sts_kept;

        // undefined threshold code keeps raising its fault flag
        if (!sdc_valid(r.sdc))
        begin
            next_r.flags[`RSC_BIT_TSF] = 1'b1;
            soft_fault = 1'b1;
        end

        // powerdown flag rises on entry to idle or sleep
        if (low_power_i && !r.lp_d)
        begin
            next_r.pdown = 1'b1;
        end

        // watchdog expiry
        if (wdt_expire_i)
        begin
            next_r.expiry = 1'b1;
            if (low_power_i)
            begin
                next_r.pdown       = 1'b1;
                next_r.pc_sp_clear = 1'b1;
            end
            else
            begin
                wdt_run_exp = 1'b1;
            end
        end

        if (sd_trip)
        begin
            next_r.flags[`RSC_BIT_SDF] = 1'b1;
        end

        // reset sequencer
        case (r.seq)
            rsc_pkg::RSC_SEQ_IDLE:
            begin
                if (sd_trip || wdt_run_exp)
                begin
                    next_r.seq      = rsc_pkg::RSC_SEQ_PULSE;
                    next_r.keep_sdc = sd_trip && !wdt_run_exp;
                end
                else if (soft_fault)
                begin
                    next_r.seq      = rsc_pkg::RSC_SEQ_WAIT;
                    next_r.cnt      = '0;
                    next_r.keep_sdc = 1'b0;
                end
            end
            rsc_pkg::RSC_SEQ_WAIT:
            begin
                if (sd_trip || wdt_run_exp)
                begin
                    next_r.seq      = rsc_pkg::RSC_SEQ_PULSE;
                    next_r.keep_sdc = 1'b0;
                end
                else if (r.cnt == SRESET_LAST)
                begin
                    next_r.seq = rsc_pkg::RSC_SEQ_PULSE;
                end
                else
                begin
                    next_r.cnt = r.cnt + 16'h0001;
                end
            end
            rsc_pkg::RSC_SEQ_PULSE:
            begin
                // full device reset; flags and this block's irq state survive
                next_r.sys_reset = 1'b1;
                next_r.init      = '1;
                next_r.wdtc      = `RSC_WDTC_POR;
                if (!r.keep_sdc)
                begin
                    next_r.sdc = `RSC_SDC_POR;
                end
                next_r.seq = rsc_pkg::RSC_SEQ_IDLE;
            end
            default:
            begin
                next_r.seq = rsc_pkg::RSC_SEQ_IDLE;
            end
        endcase

        // watchdog controls follow the register
        next_r.wdt_en  = wkey_on(next_r.wdtc);
        next_r.wdt_sel = next_r.wdtc[`RSC_WSEL_HI:0];

        // bus answer one cycle after the request, unmapped reads zero
        if (bus_req)
        begin
            next_r.ack = 1'b1;
            next_r.dat = 8'h00;
            if (adr_is(wb_adr_i, `RSC_ADR_SDC))
            begin
                next_r.dat = r.sdc;
            end
            if (adr_is(wb_adr_i, `RSC_ADR_FLAGS))
            begin
                next_r.dat = {5'h00, r.flags};
            end
            if (adr_is(wb_adr_i, `RSC_ADR_IRQ_STS))
            begin
                next_r.dat = {4'h0, r.irq_sts};
            end
            if (adr_is(wb_adr_i, `RSC_ADR_IRQ_MSK))
            begin
                next_r.dat = {4'h0, r.irq_msk};
            end
            if (adr_is(wb_adr_i, `RSC_ADR_WDTC))
            begin
                next_r.dat = r.wdtc;
            end
            if (adr_is(wb_adr_i, `RSC_ADR_STATUS))
            begin
                next_r.dat = {4'h0, sd_armed, r.lp_d, r.pdown, r.expiry};
            end
        end

        next_r.irq = |(next_r.irq_sts & next_r.irq_msk);
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers; power-on values

    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            r             <= '0;
            r.seq         <= rsc_pkg::RSC_SEQ_IDLE;
            r.sdc         <= `RSC_SDC_POR;
            r.wdtc        <= `RSC_WDTC_POR;
            r.wdt_en      <= 1'b1;
            r.wdt_sel     <= `RSC_WSEL_POR;
            r.flags       <= 3'h0;
            r.expiry      <= 1'b0;
            r.pdown       <= 1'b0;
            r.sys_reset   <= 1'b1;
            r.init        <= '1;
        end
        else
        begin
            r <= next_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign wb_dat_o      = {24'h000000, r.dat};
    assign wb_ack_o      = r.ack;
    assign sys_reset_o   = r.sys_reset;
    assign pc_sp_clear_o = r.pc_sp_clear;
    assign init_o        = r.init;
    assign wdt_enable_o  = r.wdt_en;
    assign wdt_period_o  = r.wdt_sel;
    assign irq_o         = r.irq;

endmodule // rsc_top
`default_nettype wire

// >>> verif/rsc_top_sva.sv
// port assertions of the reset-source controller
`timescale 1ns/1ps
`default_nettype none

module rsc_top_sva #(
    parameter int SRESET_NS   = 45000,
    parameter int DEBOUNCE_NS = 120000
) (
    // clock and reset
    input wire logic               clk_sys_i,
    input wire logic               rst_i,
    // bus
    input wire logic               wb_cyc_i,
    input wire logic               wb_stb_i,
    input wire logic        [31:0] wb_dat_o,
    input wire logic               wb_ack_o,
    // conditions and actions
    input wire logic               low_power_i,
    input wire logic               wdt_expire_i,
    input wire logic               sys_reset_o,
    input wire logic               pc_sp_clear_o,
    input wire rsc_pkg::rsc_init_t init_o
);
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (rst_i);

    sequence full_rst_s;
        $rose(sys_reset_o) ##1 !sys_reset_o;
    endsequence
    sequence pcsp_s;
        $rose(pc_sp_clear_o) && !sys_reset_o ##1 !pc_sp_clear_o;
    endsequence

    ack_resp_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus request not answered next cycle");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    rd_upper_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
        else $error("upper read data not zero");
    init_after_a: assert property ($rose(sys_reset_o) |-> init_o == 6'h3F)
        else $error("init commands missing with full reset");
    init_cause_a: assert property (init_o != 6'h00 |-> sys_reset_o)
        else $error("init commands without a full reset");
    rst_pulse_a: assert property ($rose(sys_reset_o) |-> full_rst_s)
        else $error("full reset not a single pulse");
    exp_full_a: assert property (wdt_expire_i && !low_power_i |-> ##[1:2] full_rst_s)
        else $error("expiry while running gave no full reset");
    exp_lp_a: assert property (wdt_expire_i && low_power_i |-> ##[1:2] pcsp_s)
        else $error("expiry in low power gave no pc/sp clear");
endmodule // rsc_top_sva

////////////////////////////////////////////////////////////////////////////////
bind rsc_top rsc_top_sva #(.SRESET_NS(SRESET_NS), .DEBOUNCE_NS(DEBOUNCE_NS)) u_sva (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .low_power_i(low_power_i),
    .wdt_expire_i(wdt_expire_i), .sys_reset_o(sys_reset_o),
    .pc_sp_clear_o(pc_sp_clear_o), .init_o(init_o));

`default_nettype wire

// >>> verif/rsc_top_tb.sv
// self-checking bench of the reset-source controller
`timescale 1ns/1ps
`default_nettype none
`include "rsc_cfg.svh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_count++; \
    $display("ERROR t=%0t got %0h exp %0h", $time, (g), (e)); end end

module rsc_top_tb;
    localparam int SR  = 10;
    localparam int DEB = 10;
    logic               clk_sys_i    = 1'b0;
    logic               rst_i        = 1'b1;
    logic               wb_cyc_i     = 1'b0;
    logic               wb_stb_i     = 1'b0;
    logic               wb_we_i      = 1'b0;
    logic        [7:0]  wb_adr_i     = 8'h00;
    logic        [31:0] wb_dat_i     = 32'h0;
    logic               low_voltage_i = 1'b0;
    logic               low_power_i  = 1'b0;
    logic               wdt_expire_i = 1'b0;
    logic        [31:0] wb_dat_o;
    logic               wb_ack_o;
    logic               sys_reset_o;
    logic               pc_sp_clear_o;
    rsc_pkg::rsc_init_t init_o;
    logic               wdt_enable_o;
    logic        [2:0]  wdt_period_o;
    logic               irq_o;
    logic        [7:0]  rd;
    int                 n;
    int                 err_count    = 0;
    int                 num_checks   = 0;

    rsc_top #(.SRESET_NS(400), .DEBOUNCE_NS(400)) u_dut (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'h1), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .low_voltage_i(low_voltage_i),
        .low_power_i(low_power_i), .wdt_expire_i(wdt_expire_i), .sys_reset_o(sys_reset_o),
        .pc_sp_clear_o(pc_sp_clear_o), .init_o(init_o), .wdt_enable_o(wdt_enable_o),
        .wdt_period_o(wdt_period_o), .irq_o(irq_o));

    initial
    begin
        forever #20 clk_sys_i = ~clk_sys_i;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] d);
        int k;
        @(posedge clk_sys_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_dat_i <= {24'h0, d};
        k = 0;
        do
        begin
            @(posedge clk_sys_i);
            k++;
        end
        while (wb_ack_o !== 1'b1 && k < 20);
        rd = wb_dat_o[7:0];
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (k >= 20)
        begin
            err_count++;
            end_of_test();
        end
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        wb(1'b0, a, 8'h00);
        `CHK(rd & m, e)
    endtask

    // counts edges until the chosen pulse is seen, lim if never
    task automatic wait_pulse(input bit pcsp, input int lim);
        n = 0;
        while (((pcsp ? pc_sp_clear_o : sys_reset_o) !== 1'b1) && n < lim)
        begin
            @(posedge clk_sys_i);
            n++;
        end
    endtask

    task automatic pulse_exp();
        @(posedge clk_sys_i);
        wdt_expire_i <= 1'b1;
        @(posedge clk_sys_i);
        wdt_expire_i <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_por();
        rchk(`RSC_ADR_SDC, 8'hFF, `RSC_SDC_POR);
        rchk(`RSC_ADR_FLAGS, 8'hFF, 8'h00);
        rchk(`RSC_ADR_WDTC, 8'hFF, `RSC_WDTC_POR);
        rchk(`RSC_ADR_STATUS, 8'h03, 8'h00);
        rchk(8'h40, 8'hFF, 8'h00);
        `CHK({wdt_enable_o, wdt_period_o, irq_o}, 5'h16)
        $display("test por done");
    endtask

    task automatic t_codes();
        wb(1'b1, `RSC_ADR_SDC, `RSC_SDC_OFF);
        rchk(`RSC_ADR_SDC, 8'hFF, `RSC_SDC_OFF);
        low_voltage_i <= 1'b1;
        wait_pulse(1'b0, DEB + 6);
        `CHK(n, DEB + 6)
        low_voltage_i <= 1'b0;
        rchk(`RSC_ADR_FLAGS, 8'hFF, 8'h00);
        wb(1'b1, `RSC_ADR_SDC, `RSC_SDC_POR);
        $display("test codes done");
    endtask

    task automatic t_bad_sdc();
        wb(1'b1, `RSC_ADR_IRQ_MSK, 8'h02);
        wb(1'b1, `RSC_ADR_SDC, 8'h33);
        wait_pulse(1'b0, 40);
        `CHK(n >= SR - 2 && n <= SR + 2, 1'b1)
        rchk(`RSC_ADR_SDC, 8'hFF, `RSC_SDC_POR);
        rchk(`RSC_ADR_FLAGS, 8'hFF, 8'h02);
        `CHK(irq_o, 1'b1)
        wb(1'b1, `RSC_ADR_FLAGS, 8'h00);
        rchk(`RSC_ADR_FLAGS, 8'hFF, 8'h00);
        wb(1'b1, `RSC_ADR_IRQ_STS, 8'h02);
        rchk(`RSC_ADR_IRQ_STS, 8'hFF, 8'h00);
        `CHK(irq_o, 1'b0)
        $display("test bad threshold code done");
    endtask

    task automatic t_wdt();
        pulse_exp();
        wait_pulse(1'b0, 6);
        `CHK(n < 6, 1'b1)
        rchk(`RSC_ADR_STATUS, 8'h03, 8'h01);
        wb(1'b1, `RSC_ADR_WDTC, 8'h51);
        low_power_i <= 1'b1;
        pulse_exp();
        wait_pulse(1'b1, 6);
        `CHK(n < 6, 1'b1)
        wait_pulse(1'b0, 6);
        `CHK(n, 6)
        rchk(`RSC_ADR_STATUS, 8'h03, 8'h03);
        rchk(`RSC_ADR_SDC, 8'hFF, `RSC_SDC_POR);
        rchk(`RSC_ADR_WDTC, 8'hFF, 8'h51);
        low_power_i <= 1'b0;
        $display("test watchdog expiry done");
    endtask

    task automatic t_lvr();
        low_voltage_i <= 1'b1;
        wait_pulse(1'b0, DEB - 2);
        low_voltage_i <= 1'b0;
        wait_pulse(1'b0, 4);
        `CHK(n, 4)
        low_power_i <= 1'b1;
        low_voltage_i <= 1'b1;
        wait_pulse(1'b0, DEB + 6);
        `CHK(n, DEB + 6)
        low_power_i <= 1'b0;
        low_voltage_i <= 1'b0;
        @(posedge clk_sys_i);
        low_voltage_i <= 1'b1;
        wait_pulse(1'b0, DEB + 6);
        `CHK(n >= DEB && n <= DEB + 4, 1'b1)
        low_voltage_i <= 1'b0;
        rchk(`RSC_ADR_FLAGS, 8'hFF, 8'h04);
        rchk(`RSC_ADR_SDC, 8'hFF, `RSC_SDC_POR);
        rchk(`RSC_ADR_IRQ_STS, 8'h0C, 8'h0C);
        rchk(`RSC_ADR_STATUS, 8'h03, 8'h03);
        wb(1'b1, `RSC_ADR_FLAGS, 8'h00);
        rchk(`RSC_ADR_FLAGS, 8'hFF, 8'h00);
        $display("test supply drop done");
    endtask

    task automatic t_wkey();
        wb(1'b1, `RSC_ADR_WDTC, 8'h50);
        rchk(`RSC_ADR_WDTC, 8'hFF, 8'h50);
        `CHK({wdt_enable_o, wdt_period_o}, 4'h8)
        wb(1'b1, `RSC_ADR_WDTC, 8'hA8);
        rchk(`RSC_ADR_WDTC, 8'hFF, 8'hA8);
        `CHK(wdt_enable_o, 1'b0)
        wb(1'b1, `RSC_ADR_WDTC, 8'h18);
        wait_pulse(1'b0, 40);
        `CHK(n >= SR - 2 && n <= SR + 2, 1'b1)
        rchk(`RSC_ADR_FLAGS, 8'hFF, 8'h01);
        `CHK({irq_o, wdt_enable_o}, 2'h1)
        rchk(`RSC_ADR_WDTC, 8'hFF, `RSC_WDTC_POR);
        wb(1'b1, `RSC_ADR_FLAGS, 8'h00);
        rchk(`RSC_ADR_FLAGS, 8'hFF, 8'h00);
        $display("test watchdog key done");
    endtask

    initial
    begin
        repeat (16) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        t_por();
        t_codes();
        t_bad_sdc();
        t_wdt();
        t_lvr();
        t_wkey();
        end_of_test();
    end
endmodule // rsc_top_tb

`default_nettype wire
